// [fcct_cfg.svh]
// Holds register offsets, field positions and reset values.
// Assumes inclusion by the timer package and modules only.
`ifndef FCCT_CFG_SVH
`define FCCT_CFG_SVH

`define FCCT_OFF_IO_SELECT   8'h00
`define FCCT_OFF_CTRL_ONE    8'h04
`define FCCT_OFF_COUNTER     8'h08
`define FCCT_OFF_CTRL_TWO    8'h0C
`define FCCT_OFF_EDGE        8'h10
`define FCCT_OFF_STATUS      8'h14
`define FCCT_OFF_CLEAR       8'h18
`define FCCT_OFF_IRQ_EN      8'h1C
`define FCCT_OFF_CH0         8'h20
`define FCCT_OFF_PORT_DIR    8'h30
`define FCCT_OFF_PORT_DATA   8'h34

`define FCCT_CTRL_ONE_EN     7
`define FCCT_CTRL_ONE_FFCA   4
`define FCCT_CTRL_TWO_CH3_COUNTER_RESET_ENABLE   3
`define FCCT_STAT_OVF        4

`define FCCT_CNT_MAX         16'hFFFF
`define FCCT_RST_WORD        32'h0000_0000
`define FCCT_RST_DIR         8'h00
`define FCCT_DIR_USED        8'h0F

`endif

// [fcct_pin_source.sv]
// External pulse source on the four channel pins.
// Assumes the source lets go of a pin that the timer drives.
`timescale 1ns/1ns
module fcct_pin_source (
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_pin_out,
    input  wire logic [3:0] i_pin_oe,
    output logic      [3:0] o_pin_level
);
    logic [3:0] src_q = 4'h0;

    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & src_q);

    // Width never below three clocks
    task automatic pulse(input int ch, input int width);
        @(posedge i_clk_sys);
        src_q[ch] <= 1'b1;
        repeat ((width < 3) ? 3 : width) @(posedge i_clk_sys);
        src_q[ch] <= 1'b0;
    endtask : pulse
endmodule : fcct_pin_source

// [fcct_pin_sync.sv]
// Three-stage synchroniser with edge pulses for pin inputs.
// Assumes asynchronous pins and one system clock.
`timescale 1ns/1ns
module fcct_pin_sync
    import fcct_pkg::*;
#(
    parameter int W = 5
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;
    logic [W-1:0] rise_d;
    logic [W-1:0] fall_d;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // Level moves only once stages two and three agree
            always_comb begin
                lvl_d[g]  = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
                rise_d[g] = lvl_d[g] & ~lvl_q[g];
                fall_d[g] = ~lvl_d[g] & lvl_q[g];
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            lvl_q   <= '0;
            o_level <= '0;
            o_rise  <= '0;
            o_fall  <= '0;
        end else begin
            s1_q    <= i_pin;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            lvl_q   <= lvl_d;
            o_level <= lvl_d;
            o_rise  <= rise_d;
            o_fall  <= fall_d;
        end
    end

endmodule : fcct_pin_sync

// [fcct_pkg.sv]
// Types shared by the timer modules.
// Assumes fcct_cfg.svh sits in the include path.
package fcct_pkg;

    // Capture edge mode of one channel
    typedef enum logic [1:0] {
        FCCT_EDGE_OFF  = 2'h0,
        FCCT_EDGE_RISE = 2'h1,
        FCCT_EDGE_FALL = 2'h2,
        FCCT_EDGE_BOTH = 2'h3
    } fcct_edge_t;

endpackage : fcct_pkg

// [fcct_timer.sv]
// One timer instance: counter, prescaler, four capture channels,
// pin GPIO and an AHB-Lite register slave.
// Assumes one AHB-Lite master, zero-wait slave, pins asynchronous.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`include "fcct_cfg.svh"
`timescale 1ns/1ns
module fcct_timer
    import fcct_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hwdata,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic [3:0]  i_timer_port_pin,
    output logic      [3:0]  o_timer_port_pin,
    output logic      [3:0]  o_timer_port_pin_oe,
    input  wire logic        i_sync_clear,
    output logic             o_irq
);
    // Register hit on a word offset
    function automatic logic fcct_hit(input logic [7:0] a, input logic [7:0] off);
        return (a[7:2] == off[7:2]);
    endfunction : fcct_hit

    // Edge qualifier for one channel
    function automatic logic fcct_edge_hit(input fcct_edge_t m, input logic r,
                                           input logic f);
        return ((m == FCCT_EDGE_RISE) && r) || ((m == FCCT_EDGE_FALL) && f) ||
               ((m == FCCT_EDGE_BOTH) && (r || f));
    endfunction : fcct_edge_hit

    logic [4:0]  pin_lvl;
    logic [4:0]  pin_rise;
    logic [4:0]  pin_fall;

    logic [3:0]  ios_q,  ios_d;
    logic [7:0]  ctl1_q, ctl1_d;
    logic [7:0]  ctl2_q, ctl2_d;
    logic [7:0]  edge_q, edge_d;
    logic [4:0]  flag_q, flag_d;
    logic [4:0]  ien_q,  ien_d;
    logic [15:0] cnt_q,  cnt_d;
    logic [6:0]  pre_q,  pre_d;
    logic [15:0] chv_q [4];
    logic [15:0] chv_d [4];
    logic [7:0]  dir_q,  dir_d;
    logic [3:0]  pdat_q, pdat_d;
    logic        wr_q,   wr_d;
    logic [7:0]  adr_q,  adr_d;
    logic [31:0] rdat_d;
    logic        irq_d;

    logic        aphase;
    logic        tick;
    logic        ch3_counter_reset_enable;
    logic [6:0]  mask;
    logic [3:0]  pin_rd;

    fcct_pin_sync #(
        .W (5)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_pin     ({i_sync_clear, i_timer_port_pin}),
        .o_level   (pin_lvl),
        .o_rise    (pin_rise),
        .o_fall    (pin_fall)
    );

    always_comb begin
        ios_d  = ios_q;
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        edge_d = edge_q;
        flag_d = flag_q;
        ien_d  = ien_q;
        cnt_d  = cnt_q;
        pre_d  = pre_q;
        chv_d  = chv_q;
        dir_d  = dir_q;
        pdat_d = pdat_q;
        rdat_d = `FCCT_RST_WORD;
        aphase = i_hsel && i_htrans[1] && i_hready;
        wr_d   = aphase && i_hwrite;
        adr_d  = aphase ? i_haddr[7:0] : adr_q;
        ch3_counter_reset_enable   = ctl2_q[`FCCT_CTRL_TWO_CH3_COUNTER_RESET_ENABLE];
        // Prescaler mask: divide by 2**select
        mask   = 7'((8'h01 << ctl2_q[2:0]) - 8'h01);
        tick   = ctl1_q[`FCCT_CTRL_ONE_EN] && ((pre_q & mask) == mask);
        // GPIO read: pin level for inputs, latch for outputs
        pin_rd = (pin_lvl[3:0] & ~dir_q[3:0]) | (pdat_q & dir_q[3:0]);

        // Register writes in the data phase
        if (wr_q) begin
            if (fcct_hit(adr_q, `FCCT_OFF_IO_SELECT)) ios_d  = i_hwdata[3:0];
            if (fcct_hit(adr_q, `FCCT_OFF_CTRL_ONE))  ctl1_d = i_hwdata[7:0];
            if (fcct_hit(adr_q, `FCCT_OFF_CTRL_TWO))  ctl2_d = i_hwdata[7:0];
            if (fcct_hit(adr_q, `FCCT_OFF_EDGE))      edge_d = i_hwdata[7:0];
            if (fcct_hit(adr_q, `FCCT_OFF_CLEAR))     flag_d = flag_q & ~i_hwdata[4:0];
            if (fcct_hit(adr_q, `FCCT_OFF_IRQ_EN))    ien_d  = i_hwdata[4:0];
            // Low four bits steer pins; upper ones held at zero
            if (fcct_hit(adr_q, `FCCT_OFF_PORT_DIR))  dir_d  = i_hwdata[7:0] & `FCCT_DIR_USED;
            if (fcct_hit(adr_q, `FCCT_OFF_PORT_DATA)) pdat_d = i_hwdata[3:0];
            for (int c = 0; c < 4; c++) begin
                if (fcct_hit(adr_q, 8'(`FCCT_OFF_CH0 + 4 * c))) chv_d[c] = i_hwdata[15:0];
            end
        end

        // Any counter access clears the overflow flag while FCCT_CTRL_ONE_FFCA is set, unless an overflow falls in the same cycle
        if (aphase && ctl1_q[`FCCT_CTRL_ONE_FFCA] && fcct_hit(i_haddr[7:0], `FCCT_OFF_COUNTER)) begin
            flag_d[`FCCT_STAT_OVF] = 1'b0;
        end

        // Counter and prescaler; sync input holds both clear
        if (pin_lvl[4]) begin
            cnt_d = 16'h0000;
            pre_d = 7'h00;
        end else if (ctl1_q[`FCCT_CTRL_ONE_EN]) begin
            pre_d = pre_q + 7'h01;
            if (tick) begin
                if (ch3_counter_reset_enable && (cnt_q == chv_q[3])) begin
                    cnt_d = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
                // Overflow re-flagged even when already set
                if ((cnt_q == `FCCT_CNT_MAX) && !(ch3_counter_reset_enable && (chv_q[3] == `FCCT_CNT_MAX))) begin
                    flag_d[`FCCT_STAT_OVF] = 1'b1;
                end
            end
        end

        // Capture: select clear, pin input, qualified edge
        for (int c = 0; c < 4; c++) begin
            if (!ios_q[c] && !dir_q[c] &&
                fcct_edge_hit(fcct_edge_t'(edge_q[2*c +: 2]), pin_rise[c], pin_fall[c])) begin
                chv_d[c]  = cnt_q;
                flag_d[c] = 1'b1;
            end
        end

        // Read data sampled at the address phase
        if (aphase && !i_hwrite) begin
            case (1'b1)
                fcct_hit(i_haddr[7:0], `FCCT_OFF_IO_SELECT): rdat_d = {28'h0, ios_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_CTRL_ONE):  rdat_d = {24'h0, ctl1_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_COUNTER):   rdat_d = {16'h0, cnt_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_CTRL_TWO):  rdat_d = {24'h0, ctl2_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_EDGE):      rdat_d = {24'h0, edge_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_STATUS):    rdat_d = {27'h0, flag_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_IRQ_EN):    rdat_d = {27'h0, ien_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_CH0):       rdat_d = {16'h0, chv_q[0]};
                fcct_hit(i_haddr[7:0], 8'(`FCCT_OFF_CH0 + 4)):  rdat_d = {16'h0, chv_q[1]};
                fcct_hit(i_haddr[7:0], 8'(`FCCT_OFF_CH0 + 8)):  rdat_d = {16'h0, chv_q[2]};
                fcct_hit(i_haddr[7:0], 8'(`FCCT_OFF_CH0 + 12)): rdat_d = {16'h0, chv_q[3]};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_PORT_DIR):  rdat_d = {24'h0, dir_q};
                fcct_hit(i_haddr[7:0], `FCCT_OFF_PORT_DATA): rdat_d = {28'h0, pin_rd};
                default:                                     rdat_d = `FCCT_RST_WORD;
            endcase
        end

        // Enabled flags raise the request
        irq_d = |(flag_d & ien_d);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ios_q               <= 4'h0;
            ctl1_q              <= 8'h00;
            ctl2_q              <= 8'h00;
            edge_q              <= 8'h00;
            flag_q              <= 5'h00;
            ien_q               <= 5'h00;
            cnt_q               <= 16'h0000;
            pre_q               <= 7'h00;
            chv_q               <= '{default: 16'h0000};
            dir_q               <= `FCCT_RST_DIR;
            pdat_q              <= 4'h0;
            wr_q                <= 1'b0;
            adr_q               <= 8'h00;
            o_hrdata            <= `FCCT_RST_WORD;
            o_hreadyout         <= 1'b1;
            o_hresp             <= 1'b0;
            o_timer_port_pin    <= 4'h0;
            o_timer_port_pin_oe <= 4'h0;
            o_irq               <= 1'b0;
        end else begin
            ios_q               <= ios_d;
            ctl1_q              <= ctl1_d;
            ctl2_q              <= ctl2_d;
            edge_q              <= edge_d;
            flag_q              <= flag_d;
            ien_q               <= ien_d;
            cnt_q               <= cnt_d;
            pre_q               <= pre_d;
            chv_q               <= chv_d;
            dir_q               <= dir_d;
            pdat_q              <= pdat_d;
            wr_q                <= wr_d;
            adr_q               <= adr_d;
            o_hrdata            <= rdat_d;
            o_hreadyout         <= 1'b1;
            o_hresp             <= 1'b0;
            o_timer_port_pin    <= pdat_d;
            o_timer_port_pin_oe <= dir_d[3:0];
            o_irq               <= irq_d;
        end
    end

endmodule : fcct_timer

// [fcct_timer_properties.sv]
// Concurrent checks on one timer instance, seen from its ports.
// Assumes AHB-Lite address phases on the ports and reset active high.
`timescale 1ns/1ns
module fcct_timer_properties (
    input wire logic        i_clk_sys,
    input wire logic        i_srst,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic [31:0] i_hwdata,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [3:0]  o_timer_port_pin_oe,
    input wire logic        i_sync_clear,
    input wire logic        o_irq
);
    wire logic [7:0] addr_lo = i_haddr[7:0];
    wire logic       take    = i_hsel & i_htrans[1] & i_hready;
    wire logic       rd      = take & ~i_hwrite;
    wire logic       wr      = take & i_hwrite;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    property p_ready; o_hreadyout && !o_hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus wait or error seen");
    property p_rst_oe; disable iff (1'b0) i_srst |=> o_timer_port_pin_oe == 4'h0; endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("pin driven in reset");
    property p_rst_irq; disable iff (1'b0) i_srst |=> !o_irq; endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq high in reset");
    property p_sync; i_sync_clear [*6] ##0 (rd && addr_lo == 8'h08) |=> o_hrdata == 32'h0;
    endproperty
    a_sync: assert property (p_sync) else $error("counter not held by sync");
    property p_cnt_w; rd && addr_lo == 8'h08 |=> o_hrdata[31:16] == 16'h0; endproperty
    a_cnt_w: assert property (p_cnt_w) else $error("counter wider than 16");
    property p_dir_rsv; rd && addr_lo == 8'h30 |=> o_hrdata[31:4] == 28'h0; endproperty
    a_dir_rsv: assert property (p_dir_rsv) else $error("upper direction bits set");
    property p_stat_rsv; rd && addr_lo == 8'h14 |=> o_hrdata[31:5] == 27'h0; endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
    property p_dir_wr;
        logic [3:0] d;
        (wr && addr_lo == 8'h30) ##1 (1'b1, d = i_hwdata[3:0]) |-> ##[1:2] o_timer_port_pin_oe == d;
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direction not applied");
endmodule : fcct_timer_properties

bind fcct_timer fcct_timer_properties u_props (
    .i_clk_sys           (i_clk_sys),
    .i_srst              (i_srst),
    .i_hsel              (i_hsel),
    .i_haddr             (i_haddr),
    .i_htrans            (i_htrans),
    .i_hwrite            (i_hwrite),
    .i_hready            (i_hready),
    .i_hwdata            (i_hwdata),
    .o_hrdata            (o_hrdata),
    .o_hreadyout         (o_hreadyout),
    .o_hresp             (o_hresp),
    .o_timer_port_pin_oe (o_timer_port_pin_oe),
    .i_sync_clear        (i_sync_clear),
    .o_irq               (o_irq)
);

// [test_four_channel_capture_timer.sv]
// Self-checking bench: AHB-Lite register tasks and pin pulses.
// Assumes the checker binds itself and a single zero-wait slave.
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp); end end
module test_four_channel_capture_timer;
    logic        i_clk_sys = 1'b0;
    logic        i_srst    = 1'b1;
    logic        hsel      = 1'b0;
    logic        hwrite    = 1'b0;
    logic        sync      = 1'b0;
    logic [1:0]  htrans    = 2'h0;
    logic [31:0] haddr     = 32'h0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] rdata, c;
    logic [31:0] hrdata;
    logic        hready, hresp, irq;
    logic [3:0]  pin_out, pin_oe, pin_lvl;
    int          num_errors = 0;
    int          n_compared = 0;
    int          k;

    always #5 i_clk_sys = ~i_clk_sys;

    fcct_timer u_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
        .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_timer_port_pin(pin_lvl), .o_timer_port_pin(pin_out), .o_timer_port_pin_oe(pin_oe),
        .i_sync_clear(sync), .o_irq(irq));
    fcct_pin_source u_src (.i_clk_sys(i_clk_sys), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .o_pin_level(pin_lvl));

    task automatic give_verdict();
        $display("Errors %0d, compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic wait_rdy();
        k = 0;
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdata = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd

    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        rd(8'h30);
        `CHK(rdata, 32'h0)
        wr(8'h30, 32'hFF);
        rd(8'h30);
        `CHK(rdata, 32'hF)
        wr(8'h34, 32'h5);
        repeat (3) @(posedge i_clk_sys);
        `CHK({pin_oe, pin_out}, 8'hF5)
        rd(8'h34);
        `CHK(rdata, 32'h5)
        wr(8'h30, 32'h0);
        repeat (6) @(posedge i_clk_sys);
        rd(8'h34);
        `CHK(rdata, 32'h0)
        for (int s = 0; s < 8; s++) begin
            wr(8'h0C, 32'(s));
            wr(8'h04, 32'h80);
            rd(8'h08);
            c = rdata;
            repeat ((4 << s) - 3) @(posedge i_clk_sys);
            rd(8'h08);
            `CHK(16'(rdata[15:0] - c[15:0]), 16'h4)
        end
        sync <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        rd(8'h08);
        `CHK(rdata, 32'h0)
        wr(8'h2C, 32'h3);
        wr(8'h0C, 32'h8);
        sync <= 1'b0;
        repeat (4) begin
            rd(8'h08);
            `CHK(rdata[31:2], 30'h0)
        end
        wr(8'h0C, 32'h0);
        wr(8'h1C, 32'h10);
        for (int t = 0; t < 70000 && irq !== 1'b1; t++) @(posedge i_clk_sys);
        `CHK(irq, 1'b1)
        if (irq !== 1'b1) give_verdict();
        rd(8'h14);
        `CHK(rdata, 32'h10)
        wr(8'h04, 32'h90);
        rd(8'h08);
        rd(8'h14);
        `CHK(rdata, 32'h0)
        wr(8'h04, 32'h0);
        rd(8'h08);
        c = rdata;
        wr(8'h00, 32'h8);
        wr(8'h10, 32'hD6);
        wr(8'h1C, 32'h2);
        wr(8'h30, 32'h4);
        u_src.pulse(0, 4);
        u_src.pulse(1, 4);
        u_src.pulse(3, 4);
        repeat (8) @(posedge i_clk_sys);
        rd(8'h14);
        `CHK(rdata, 32'h3)
        rd(8'h20);
        `CHK(rdata, c)
        rd(8'h24);
        `CHK(rdata, c)
        `CHK(irq, 1'b1)
        wr(8'h1C, 32'h0);
        repeat (2) @(posedge i_clk_sys);
        `CHK(irq, 1'b0)
        wr(8'h18, 32'h1F);
        rd(8'h14);
        `CHK(rdata, 32'h0)
        give_verdict();
    end
endmodule : test_four_channel_capture_timer
